// ==== pkg/ael_defs.svh ====
`ifndef AEL_DEFS_SVH
`define AEL_DEFS_SVH

`define AEL_CLK_HZ 50000000
`define AEL_BAUD 9600
`define AEL_GAP_BITS 39
`define AEL_BAUD_W 16
`define AEL_GAP_W 24
`define AEL_SEC_W 26

`define AEL_FN_READ 8'h03
`define AEL_FN_WRITE 8'h06
`define AEL_FRAME_BYTES 4'h8
`define AEL_MAX_QTY 16'h007D
`define AEL_CRC_INIT 16'hFFFF
`define AEL_CRC_POLY 16'hA001

`define AEL_CAL_BASE 16'h020A
`define AEL_CAL_MONTH 16'h020B
`define AEL_CAL_DATE 16'h020C
`define AEL_CAL_HOUR 16'h020D
`define AEL_CAL_MINUTE 16'h020E
`define AEL_CAL_SECOND 16'h020F
`define AEL_CAL_LAST 16'h0210

`define AEL_LOG_BASE 16'h0800
`define AEL_LOG_LAST 16'h0995
`define AEL_LOG_DEPTH 30
`define AEL_LOG_FULL 5'h1E
`define AEL_ENTRY_WORDS 16'h0005
`define AEL_ENTRY_BITS 80

`define AEL_TYPE_MIN 8'h01
`define AEL_TYPE_MAX 8'h05
`define AEL_CHAN_MIN 8'h01
`define AEL_CHAN_RSVD 8'h0B
`define AEL_CHAN_MAX 8'h14

`define AEL_CAL_RST_YEAR 8'h00
`define AEL_CAL_RST_ONE 8'h01

`endif

// ==== pkg/ael_pkg.sv ====
package ael_pkg;
`include "ael_defs.svh"

	typedef enum logic [3:0] {
		AEL_RX_IDLE = 4'h1,
		AEL_RX_START = 4'h2,
		AEL_RX_DATA = 4'h4,
		AEL_RX_STOP = 4'h8
	} ael_rx_e;

	typedef enum logic [1:0] {
		AEL_TX_IDLE = 2'h1,
		AEL_TX_SHIFT = 2'h2
	} ael_tx_e;

	typedef struct packed {
		logic [7:0] kind;
		logic [7:0] chan;
		logic [15:0] value;
	} ael_evt_s;

	typedef struct packed {
		logic [7:0] year;
		logic [7:0] month;
		logic [7:0] date;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
		logic [7:0] wday;
	} ael_cal_s;

	typedef logic [`AEL_LOG_DEPTH-1:0][`AEL_ENTRY_BITS-1:0] ael_log_t;

	typedef struct packed {
		ael_rx_e rx_st;
		logic [`AEL_BAUD_W-1:0] rx_cnt;
		logic [2:0] rx_bit;
		logic [7:0] rx_sh;
		logic [`AEL_GAP_W-1:0] gap;
		logic [63:0] fb;
		logic [3:0] nbytes;
		logic [15:0] crc;
		ael_tx_e tx_st;
		logic [`AEL_BAUD_W-1:0] tx_cnt;
		logic [3:0] tx_bit;
		logic [9:0] tx_sh;
		logic resp_act;
		logic [7:0] resp_func;
		logic [7:0] resp_idx;
		logic [7:0] resp_len;
		logic [15:0] tcrc;
		logic [15:0] cur_addr;
		logic [`AEL_SEC_W-1:0] sec_cnt;
		ael_cal_s cal;
		ael_log_t log;
		logic [4:0] count;
	} ael_state_s;

endpackage

// ==== hdl/ael_top.sv ====
`timescale 1ns/1ps
// Summary of operation
// - thirty alarm entries at 0x800 through 0x895, reads accepted to 0x995
// - bytes two, three hold fault value
// - bytes four to nine timestamp fields
// - fault type codes one to five
// - channel codes one to ten
// - channel eleven reserved, twelve to twenty
// - calendar registers 0x20A to 0x210
// - writes use function 06, one register
// - writes refused unless enabled
// - failed write sends no reply
// - unimplemented read address gets no data
// - function 03 frames, CRC16, big-endian words
module ael_top import ael_pkg::*; #(
	parameter int BAUD_CLKS = `AEL_CLK_HZ / `AEL_BAUD,
	parameter int SEC_CLKS = `AEL_CLK_HZ
) (
	input wire logic mclk, // system clock, 50 MHz
	input wire logic rstn, // asynchronous reset, active low
	input wire logic rxd, // rs485 receive data
	input wire logic [7:0] slave_addr, // modbus station address
	input wire logic write_en_cfg, // settings allow function 06
	input wire logic evt_valid, // one-cycle alarm event strobe
	input wire ael_evt_s evt, // alarm event type, channel, value
	output logic txd, // rs485 transmit data
	output logic drv_en_n, // rs485 driver enable, low while driving
	output ael_cal_s cal_out, // current calendar
	output logic [4:0] log_count // occupied log entries
);
	localparam logic [`AEL_BAUD_W-1:0] BIT_L = `AEL_BAUD_W'(BAUD_CLKS - 1);
	localparam logic [`AEL_BAUD_W-1:0] HALF_L = `AEL_BAUD_W'(BAUD_CLKS / 2);
	localparam logic [`AEL_GAP_W-1:0] GAP_L = `AEL_GAP_W'(BAUD_CLKS * `AEL_GAP_BITS);
	localparam logic [`AEL_SEC_W-1:0] SEC_L = `AEL_SEC_W'(SEC_CLKS - 1);

	logic [1:0] rst_sync_ff;
	logic rst_s;
	ael_state_s s_ff;
	ael_state_s nxt_s;
	logic frame_ok;
	logic rd_ok;
	logic wr_ok;
	logic evt_ok;
	logic [15:0] req_addr;
	logic [15:0] req_val;
	logic [7:0] req_func;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_s = rst_sync_ff[1];

	function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ `AEL_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	function automatic logic [7:0] month_days(input logic [7:0] mon, input logic [7:0] yr);
		logic [7:0] d;
		case (mon)
			8'h02: d = (yr[1:0] == 2'h0) ? 8'h1D : 8'h1C;
			8'h04, 8'h06, 8'h09, 8'h0B: d = 8'h1E;
			default: d = 8'h1F;
		endcase
		return d;
	endfunction

	function automatic logic [15:0] rd_word(input logic [15:0] a, input ael_cal_s c,
			input ael_log_t lg);
		logic [15:0] w;
		logic [15:0] e;
		logic [15:0] j;
		w = a - `AEL_LOG_BASE;
		e = w / `AEL_ENTRY_WORDS;
		j = w % `AEL_ENTRY_WORDS;
		rd_word = 16'h0000;
		if (a >= `AEL_CAL_BASE && a <= `AEL_CAL_LAST) begin
			case (a)
				`AEL_CAL_BASE: rd_word = {8'h00, c.year};
				`AEL_CAL_MONTH: rd_word = {8'h00, c.month};
				`AEL_CAL_DATE: rd_word = {8'h00, c.date};
				`AEL_CAL_HOUR: rd_word = {8'h00, c.hour};
				`AEL_CAL_MINUTE: rd_word = {8'h00, c.minute};
				`AEL_CAL_SECOND: rd_word = {8'h00, c.second};
				default: rd_word = {8'h00, c.wday};
			endcase
		end else if (e < 16'(`AEL_LOG_DEPTH)) begin
			rd_word = lg[e[4:0]][`AEL_ENTRY_BITS-1-16*j[2:0] -: 16];
		end
	endfunction

	always_comb begin
		logic tick;
		logic rx_done;
		logic [63:0] fbn;
		logic [15:0] crcn;
		logic [16:0] last;
		logic [15:0] qty;
		logic [7:0] b;
		logic [7:0] k;
		logic [15:0] word;
		tick = 1'b0;
		rx_done = 1'b0;
		fbn = '0;
		crcn = '0;
		last = '0;
		qty = '0;
		b = '0;
		k = '0;
		word = '0;
		nxt_s = s_ff;
		frame_ok = 1'b0;
		rd_ok = 1'b0;
		wr_ok = 1'b0;
		req_addr = '0;
		req_val = '0;
		req_func = '0;

		// seconds divider and calendar advance
		if (s_ff.sec_cnt == SEC_L) begin
			nxt_s.sec_cnt = '0;
			tick = 1'b1;
		end else begin
			nxt_s.sec_cnt = s_ff.sec_cnt + 1'b1;
		end
		if (tick) begin
			nxt_s.cal.second = s_ff.cal.second + 8'h01;
			if (s_ff.cal.second == 8'h3B) begin
				nxt_s.cal.second = 8'h00;
				nxt_s.cal.minute = s_ff.cal.minute + 8'h01;
				if (s_ff.cal.minute == 8'h3B) begin
					nxt_s.cal.minute = 8'h00;
					nxt_s.cal.hour = s_ff.cal.hour + 8'h01;
					if (s_ff.cal.hour == 8'h17) begin
						nxt_s.cal.hour = 8'h00;
						nxt_s.cal.date = s_ff.cal.date + 8'h01;
						nxt_s.cal.wday = (s_ff.cal.wday == 8'h06) ? 8'h00 : s_ff.cal.wday + 8'h01;
						if (s_ff.cal.date >= month_days(s_ff.cal.month, s_ff.cal.year)) begin
							nxt_s.cal.date = `AEL_CAL_RST_ONE;
							nxt_s.cal.month = s_ff.cal.month + 8'h01;
							if (s_ff.cal.month >= 8'h0C) begin
								nxt_s.cal.month = `AEL_CAL_RST_ONE;
								nxt_s.cal.year = (s_ff.cal.year == 8'h63) ? 8'h00 :
									s_ff.cal.year + 8'h01;
							end
						end
					end
				end
			end
		end

		// alarm event capture
		evt_ok = evt_valid && evt.kind >= `AEL_TYPE_MIN && evt.kind <= `AEL_TYPE_MAX &&
			evt.chan >= `AEL_CHAN_MIN && evt.chan <= `AEL_CHAN_MAX &&
			evt.chan != `AEL_CHAN_RSVD;
		if (evt_ok) begin
			if (s_ff.count < `AEL_LOG_FULL) begin
				nxt_s.log[s_ff.count] = {evt, s_ff.cal[55:8]};
				nxt_s.count = s_ff.count + 5'h01;
			end else begin
				nxt_s.log = {{evt, s_ff.cal[55:8]}, s_ff.log[`AEL_LOG_DEPTH-1:1]};
			end
		end

		// uart receiver, ignored while a reply is on the wire
		case (s_ff.rx_st)
			AEL_RX_IDLE: begin
				nxt_s.rx_cnt = '0;
				if (!rxd && !s_ff.resp_act) begin
					nxt_s.rx_st = AEL_RX_START;
				end
			end
			AEL_RX_START: begin
				nxt_s.rx_cnt = s_ff.rx_cnt + 1'b1;
				if (s_ff.rx_cnt == HALF_L) begin
					nxt_s.rx_cnt = '0;
					nxt_s.rx_bit = 3'h0;
					nxt_s.rx_st = rxd ? AEL_RX_IDLE : AEL_RX_DATA;
				end
			end
			AEL_RX_DATA: begin
				nxt_s.rx_cnt = s_ff.rx_cnt + 1'b1;
				if (s_ff.rx_cnt == BIT_L) begin
					nxt_s.rx_cnt = '0;
					nxt_s.rx_sh = {rxd, s_ff.rx_sh[7:1]};
					nxt_s.rx_bit = s_ff.rx_bit + 3'h1;
					if (s_ff.rx_bit == 3'h7) begin
						nxt_s.rx_st = AEL_RX_STOP;
					end
				end
			end
			AEL_RX_STOP: begin
				nxt_s.rx_cnt = s_ff.rx_cnt + 1'b1;
				if (s_ff.rx_cnt == BIT_L) begin
					nxt_s.rx_st = AEL_RX_IDLE;
					rx_done = rxd;
				end
			end
			default: nxt_s.rx_st = AEL_RX_IDLE;
		endcase

		// silence of 39 bit times resynchronises framing
		if (s_ff.rx_st == AEL_RX_IDLE) begin
			if (s_ff.gap != GAP_L) begin
				nxt_s.gap = s_ff.gap + 1'b1;
			end else begin
				nxt_s.nbytes = 4'h0;
				nxt_s.crc = `AEL_CRC_INIT;
			end
		end else begin
			nxt_s.gap = '0;
		end

		if (rx_done) begin
			fbn = {s_ff.fb[55:0], s_ff.rx_sh};
			crcn = crc_byte(s_ff.crc, s_ff.rx_sh);
			nxt_s.fb = fbn;
			nxt_s.crc = crcn;
			nxt_s.nbytes = s_ff.nbytes + 4'h1;
			if (s_ff.nbytes == `AEL_FRAME_BYTES - 4'h1) begin
				nxt_s.nbytes = 4'h0;
				nxt_s.crc = `AEL_CRC_INIT;
				frame_ok = (crcn == 16'h0000) && (fbn[63:56] == slave_addr);
			end
		end
		req_func = fbn[55:48];
		req_addr = fbn[47:32];
		req_val = fbn[31:16];
		qty = req_val;
		last = {1'b0, req_addr} + {1'b0, qty} - 17'h00001;
		rd_ok = frame_ok && req_func == `AEL_FN_READ && qty != 16'h0000 && qty <= `AEL_MAX_QTY &&
			((req_addr >= `AEL_CAL_BASE && last <= {1'b0, `AEL_CAL_LAST}) ||
			(req_addr >= `AEL_LOG_BASE && last <= {1'b0, `AEL_LOG_LAST}));
		wr_ok = frame_ok && req_func == `AEL_FN_WRITE && write_en_cfg &&
			req_addr >= `AEL_CAL_BASE && req_addr <= `AEL_CAL_LAST;
		if (rd_ok) begin
			nxt_s.resp_act = 1'b1;
			nxt_s.resp_func = `AEL_FN_READ;
			nxt_s.resp_idx = 8'h00;
			nxt_s.resp_len = 8'(16'h0005 + {qty[14:0], 1'b0});
			nxt_s.cur_addr = req_addr;
			nxt_s.tcrc = `AEL_CRC_INIT;
		end else if (wr_ok) begin
			nxt_s.resp_act = 1'b1;
			nxt_s.resp_func = `AEL_FN_WRITE;
			nxt_s.resp_idx = 8'h00;
			nxt_s.resp_len = 8'h08;
			nxt_s.tcrc = `AEL_CRC_INIT;
			case (req_addr)
				`AEL_CAL_BASE: nxt_s.cal.year = req_val[7:0];
				`AEL_CAL_MONTH: nxt_s.cal.month = req_val[7:0];
				`AEL_CAL_DATE: nxt_s.cal.date = req_val[7:0];
				`AEL_CAL_HOUR: nxt_s.cal.hour = req_val[7:0];
				`AEL_CAL_MINUTE: nxt_s.cal.minute = req_val[7:0];
				`AEL_CAL_SECOND: nxt_s.cal.second = req_val[7:0];
				default: nxt_s.cal.wday = req_val[7:0];
			endcase
		end

		// reply byte: header, data high byte first, crc low byte first
		k = s_ff.resp_idx - 8'h03;
		word = rd_word(s_ff.cur_addr, s_ff.cal, s_ff.log);
		if (s_ff.resp_idx == s_ff.resp_len - 8'h02) begin
			b = s_ff.tcrc[7:0];
		end else if (s_ff.resp_idx == s_ff.resp_len - 8'h01) begin
			b = s_ff.tcrc[15:8];
		end else if (s_ff.resp_func == `AEL_FN_WRITE) begin
			b = s_ff.fb[63 - 8 * s_ff.resp_idx[2:0] -: 8];
		end else if (s_ff.resp_idx == 8'h00) begin
			b = slave_addr;
		end else if (s_ff.resp_idx == 8'h01) begin
			b = `AEL_FN_READ;
		end else if (s_ff.resp_idx == 8'h02) begin
			b = s_ff.resp_len - 8'h05;
		end else begin
			b = k[0] ? word[7:0] : word[15:8];
		end

		// uart transmitter
		case (s_ff.tx_st)
			AEL_TX_IDLE: begin
				if (s_ff.resp_act) begin
					if (s_ff.resp_idx == s_ff.resp_len) begin
						nxt_s.resp_act = 1'b0;
					end else begin
						nxt_s.tx_sh = {1'b1, b, 1'b0};
						nxt_s.tx_bit = 4'h0;
						nxt_s.tx_cnt = '0;
						nxt_s.tx_st = AEL_TX_SHIFT;
						nxt_s.resp_idx = s_ff.resp_idx + 8'h01;
						if (s_ff.resp_idx < s_ff.resp_len - 8'h02) begin
							nxt_s.tcrc = crc_byte(s_ff.tcrc, b);
						end
						if (s_ff.resp_func == `AEL_FN_READ && s_ff.resp_idx > 8'h02 && k[0]) begin
							nxt_s.cur_addr = s_ff.cur_addr + 16'h0001;
						end
					end
				end
			end
			AEL_TX_SHIFT: begin
				nxt_s.tx_cnt = s_ff.tx_cnt + 1'b1;
				if (s_ff.tx_cnt == BIT_L) begin
					nxt_s.tx_cnt = '0;
					nxt_s.tx_sh = {1'b1, s_ff.tx_sh[9:1]};
					nxt_s.tx_bit = s_ff.tx_bit + 4'h1;
					if (s_ff.tx_bit == 4'h9) begin
						nxt_s.tx_st = AEL_TX_IDLE;
					end
				end
			end
			default: nxt_s.tx_st = AEL_TX_IDLE;
		endcase
	end

	always_ff @(posedge mclk or negedge rst_s) begin
		if (!rst_s) begin
			s_ff <= '{rx_st: AEL_RX_IDLE, tx_st: AEL_TX_IDLE, tx_sh: 10'h3FF,
				crc: `AEL_CRC_INIT, tcrc: `AEL_CRC_INIT,
				cal: '{`AEL_CAL_RST_YEAR, `AEL_CAL_RST_ONE, `AEL_CAL_RST_ONE, 8'h00, 8'h00,
				8'h00, 8'h00}, default: '0};
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign txd = s_ff.tx_sh[0];
	assign drv_en_n = ~s_ff.resp_act;
	assign cal_out = s_ff.cal;
	assign log_count = s_ff.count;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_s);

	property p_count_max;
		s_ff.count <= `AEL_LOG_FULL;
	endproperty
	a_count_max: assert property (p_count_max) else $error("log count above thirty");

	property p_store_grow;
		evt_ok && s_ff.count < `AEL_LOG_FULL |=> s_ff.count == $past(s_ff.count) + 5'h01;
	endproperty
	a_store_grow: assert property (p_store_grow) else $error("event not appended");

	property p_bad_type;
		evt_valid && (evt.kind == 8'h00 || evt.kind > `AEL_TYPE_MAX) |=> $stable(s_ff.log);
	endproperty
	a_bad_type: assert property (p_bad_type) else $error("bad fault type stored");

	property p_bad_chan;
		evt_valid && (evt.chan == `AEL_CHAN_RSVD || evt.chan > `AEL_CHAN_MAX) |=> $stable(s_ff.log);
	endproperty
	a_bad_chan: assert property (p_bad_chan) else $error("bad channel stored");

	property p_value_time;
		evt_ok && s_ff.count < `AEL_LOG_FULL |=>
			s_ff.log[$past(s_ff.count)] == {$past(evt), $past(s_ff.cal[55:8])};
	endproperty
	a_value_time: assert property (p_value_time) else $error("entry content wrong");

	property p_overwrite;
		evt_ok && s_ff.count == `AEL_LOG_FULL |=>
			s_ff.log[0] == $past(s_ff.log[1]) && s_ff.log[29][79:48] == $past(evt);
	endproperty
	a_overwrite: assert property (p_overwrite) else $error("oldest not replaced");

	property p_write_refused;
		frame_ok && req_func == `AEL_FN_WRITE && !write_en_cfg |=> !s_ff.resp_act [*2];
	endproperty
	a_write_refused: assert property (p_write_refused) else $error("refused write answered");

	property p_write_sec;
		wr_ok && req_addr == `AEL_CAL_SECOND |=> s_ff.cal.second == $past(req_val[7:0]);
	endproperty
	a_write_sec: assert property (p_write_sec) else $error("second write lost");

	property p_sec_tick;
		s_ff.sec_cnt == SEC_L && s_ff.cal.second < 8'h3B && !wr_ok |=>
			s_ff.cal.second == $past(s_ff.cal.second) + 8'h01;
	endproperty
	a_sec_tick: assert property (p_sec_tick) else $error("calendar second not advanced");

	property p_unmapped;
		frame_ok && req_func == `AEL_FN_READ && !rd_ok |=> !s_ff.resp_act;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");

	property p_read_len;
		rd_ok |=> s_ff.resp_act && s_ff.resp_len == 8'(16'h0005 + {$past(req_val[14:0]), 1'b0});
	endproperty
	a_read_len: assert property (p_read_len) else $error("reply length wrong");

	c_read: cover property (rd_ok ##1 s_ff.resp_act);
	c_write: cover property (wr_ok);
	c_refused: cover property (frame_ok && req_func == `AEL_FN_WRITE && !write_en_cfg);
	c_overwrite: cover property (evt_ok && s_ff.count == `AEL_LOG_FULL);
endmodule

// ==== tb/ael_host.sv ====
`timescale 1ns/1ps
module ael_host #(
	parameter int BIT = 8
) (
	input wire logic mclk, // system clock
	input wire logic txd, // device transmit line
	input wire logic drv_en_n, // device driver enable, low while driving
	output logic rxd // device receive line, idles high
);
	logic [7:0] rx_q[$];

	initial rxd = 1'b1;

	// one eight-byte frame after a quiet gap; addresses go out zero-based
	task automatic send(input logic [7:0] b[8], input int gap);
		repeat (gap) @(posedge mclk);
		for (int i = 0; i < 8; i++) begin
			for (int k = 0; k < 10; k++) begin
				rxd <= (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : b[i][k-1];
				repeat (BIT) @(posedge mclk);
			end
		end
	endtask

	// collect reply bytes while the device holds the bus, bounded wait
	task automatic recv(output int n);
		int t;
		logic [7:0] v;
		rx_q.delete();
		t = 0;
		while (drv_en_n !== 1'b0 && t < 40) begin
			@(posedge mclk);
			t++;
		end
		while (drv_en_n === 1'b0 && t < 4000) begin
			if (txd === 1'b0) begin
				repeat (BIT / 2) @(posedge mclk);
				for (int k = 0; k < 8; k++) begin
					repeat (BIT) @(posedge mclk);
					v[k] = txd;
				end
				repeat (BIT) @(posedge mclk);
				rx_q.push_back(v);
			end
			@(posedge mclk);
			t++;
		end
		n = rx_q.size();
	endtask
endmodule

// ==== tb/ael_top_tb.sv ====
`timescale 1ns/1ps
module ael_top_tb;
	import ael_pkg::*;
	localparam logic [7:0] SA = 8'h0C;
	logic mclk, rstn, rxd, write_en_cfg, evt_valid, txd, drv_en_n;
	logic [7:0] slave_addr;
	logic [4:0] log_count;
	ael_evt_s evt;
	ael_cal_s cal_out;
	int err_total, checks_done;

	ael_top #(.BAUD_CLKS(8), .SEC_CLKS(1000000)) DUT (.mclk(mclk), .rstn(rstn), .rxd(rxd),
		.slave_addr(slave_addr), .write_en_cfg(write_en_cfg), .evt_valid(evt_valid),
		.evt(evt), .txd(txd), .drv_en_n(drv_en_n), .cal_out(cal_out), .log_count(log_count));
	ael_host #(.BIT(8)) host (.mclk(mclk), .txd(txd), .drv_en_n(drv_en_n), .rxd(rxd));

	always #10 mclk = ~mclk;

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk_w(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic chk_cal(input ael_cal_s got, input ael_cal_s exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i]) begin
			c ^= {8'h00, b[i]};
			repeat (8) c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		end
		return c;
	endfunction

	task automatic req(input logic [7:0] sa, input logic [7:0] fn, input logic [15:0] a,
		input logic [15:0] v, input logic bad, output int n);
		logic [7:0] q[$];
		logic [7:0] f[8];
		logic [15:0] c;
		q = {sa, fn, a[15:8], a[7:0], v[15:8], v[7:0]};
		c = crc16(q) ^ {15'h0000, bad};
		q.push_back(c[7:0]);
		q.push_back(c[15:8]);
		foreach (f[i]) f[i] = q[i];
		host.send(f, 320);
		host.recv(n);
	endtask

	task automatic nr(input logic [7:0] sa, input logic [7:0] fn, input logic [15:0] a,
		input logic [15:0] v, input logic bad);
		int n;
		req(sa, fn, a, v, bad, n);
		chk_w(16'(n), 16'h0000);
	endtask

	task automatic rd(input logic [15:0] a, input logic [15:0] exp[$]);
		int n;
		logic [15:0] qty;
		qty = 16'(exp.size());
		req(SA, 8'h03, a, qty, 1'b0, n);
		chk_w(16'(n), 16'(5 + 2 * exp.size()));
		if (n == 5 + 2 * exp.size()) begin
			chk_w({host.rx_q[0], host.rx_q[1]}, {SA, 8'h03});
			chk_w({8'h00, host.rx_q[2]}, {8'h00, qty[6:0], 1'b0});
			foreach (exp[i]) chk_w({host.rx_q[3+2*i], host.rx_q[4+2*i]}, exp[i]);
			chk_w(crc16(host.rx_q), 16'h0000);
		end
	endtask

	task automatic wr(input logic [15:0] a, input logic [15:0] v);
		int n;
		req(SA, 8'h06, a, v, 1'b0, n);
		chk_w(16'(n), 16'h0008);
		if (n == 8) begin
			chk_w({host.rx_q[2], host.rx_q[3]}, a);
			chk_w({host.rx_q[4], host.rx_q[5]}, v);
			chk_w(crc16(host.rx_q), 16'h0000);
		end
	endtask

	// events go in one per cycle with valid held high throughout
	task automatic evs(input logic [31:0] e[$]);
		foreach (e[i]) begin
			evt_valid <= 1'b1;
			evt <= e[i];
			@(posedge mclk);
		end
		evt_valid <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic t_reset();
		chk_w({15'h0000, txd}, 16'h0001);
		chk_w({15'h0000, drv_en_n}, 16'h0001);
		chk_w({11'h000, log_count}, 16'h0000);
		chk_cal(cal_out, {8'h00, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00});
	endtask

	task automatic t_refuse();
		nr(SA, 8'h06, 16'h020D, 16'h0005, 1'b0);
		nr(SA, 8'h03, 16'h0211, 16'h0001, 1'b0);
		nr(SA, 8'h03, 16'h0209, 16'h0001, 1'b0);
		nr(SA, 8'h03, 16'h020A, 16'h0008, 1'b0);
		nr(SA, 8'h03, 16'h0996, 16'h0001, 1'b0);
		nr(SA, 8'h03, 16'h020A, 16'h0000, 1'b0);
		nr(SA, 8'h03, 16'h020A, 16'h0001, 1'b1);
		nr(SA ^ 8'h01, 8'h03, 16'h020A, 16'h0001, 1'b0);
		nr(SA, 8'h10, 16'h020D, 16'h0001, 1'b0);
	endtask

	task automatic t_write();
		write_en_cfg <= 1'b1;
		wr(16'h020D, 16'h0005);
		chk_cal(cal_out, {8'h00, 8'h01, 8'h01, 8'h05, 8'h00, 8'h00, 8'h00});
		nr(SA, 8'h06, 16'h0800, 16'h0001, 1'b0);
		rd(16'h020A, {16'h0000, 16'h0001, 16'h0001, 16'h0005, 16'h0000, 16'h0000,
			16'h0000});
		write_en_cfg <= 1'b0;
	endtask

	task automatic t_events();
		evs({32'h0101_1234, 32'h0001_0001, 32'h0601_0001, 32'h020B_0001, 32'h0315_0001,
			32'h0514_BEEF, 32'h040C_0001, 32'h020A_0002, 32'h0309_0003});
		chk_w({11'h000, log_count}, 16'h0005);
		rd(16'h0800, {16'h0101, 16'h1234, 16'h0001, 16'h0105, 16'h0000,
			16'h0514, 16'hBEEF, 16'h0001, 16'h0105, 16'h0000});
		rd(16'h0814, {16'h0309, 16'h0003, 16'h0001, 16'h0105, 16'h0000});
	endtask

	task automatic t_full();
		logic [31:0] e[$];
		logic [7:0] c;
		for (int i = 0; i < 30; i++) begin
			c = 8'((i % 19) + 1);
			if (c >= 8'h0B)
				c++;
			e.push_back({8'((i % 5) + 1), c, 16'(i)});
		end
		evs(e);
		chk_w({11'h000, log_count}, 16'h001E);
		rd(16'h0800, {16'h0101, 16'h0000, 16'h0001, 16'h0105, 16'h0000});
		rd(16'h0891, {16'h050C, 16'h001D, 16'h0001, 16'h0105, 16'h0000});
		rd(16'h0995, {16'h0000});
	endtask

	initial begin
		mclk = 1'b0;
		rstn = 1'b0;
		slave_addr = SA;
		write_en_cfg = 1'b0;
		evt_valid = 1'b0;
		evt = '0;
		err_total = 0;
		checks_done = 0;
		repeat (20) @(posedge mclk);
		t_reset();
		rstn <= 1'b1;
		repeat (5) @(posedge mclk);
		rd(16'h0210, {16'h0000});
		t_refuse();
		t_write();
		t_events();
		t_full();
		finish_test();
	end

	initial begin
		repeat (100000) @(posedge mclk);
		err_total++;
		finish_test();
	end
endmodule
